//--- core/tpoi_ctrl.v
// Transmit per-frame stamp insertion control with tag FIFO and sticky errors
//
// Overview of operation
// - The two-bit select means 00 no stamp, 01 one-step insertion, 10 two-step return, 11 reserved.
// - The update-checksum flag is ignored for no-operation and two-step frames.
// - A one-step frame with the flag at 0 carries no checksum and no checksum byte is touched.
// - A one-step frame with the flag at 1 has its checksum recomputed after insertion.
// - The checksum offset is ignored unless the frame is one-step with the flag at 1.
// - The checksum offset counts bytes from destination address byte 0 to the checksum.
// - For one-step frames the stamp starts at the even stamp offset; otherwise it is ignored.
// - In transparent clock mode the stamp offset locates the correction field instead.
// - Lane skew adjust, when enabled, corrects one-step stamps by the start-of-packet lane.
// - The tag write error status goes to 1 on a write error and holds until transmit reset.
// - The tag read error status goes to 1 on a read error and holds until transmit reset.
`timescale 1ns/100ps
`include "tpoi_defines.vh"
module tpoi_ctrl (
   // Clock and transmit path reset
   input  wire        clk,
   input  wire        rst_n,
   // Per-frame sideband, taken with frame start
   input  wire        frame_start,
   input  wire [1:0]  stamp_operation_select,
   input  wire        update_checksum,
   input  wire [15:0] checksum_byte_offset,
   input  wire [15:0] stamp_byte_offset,
   input  wire [15:0] frame_tag,
   input  wire [4:0]  sop_lane,
   input  wire [63:0] reserved_rx_stamp_input,
   // Static configuration
   input  wire        lane_skew_adjust_enable,
   input  wire        transparent_clock_mode,
   // Insertion engine side, pulls one job per frame
   input  wire        job_ready,
   output reg         job_valid,
   output reg         job_insert,
   output reg         job_return_stamp,
   output reg         job_fix_checksum,
   output reg  [15:0] job_checksum_offset,
   output reg  [15:0] job_field_offset,
   output reg         job_field_is_correction,
   output reg  [15:0] job_skew_adjust,
   output reg  [15:0] job_tag,
   output reg         job_offset_error,
   // Flow control back to the client
   output reg         sideband_ready,
   // Sticky tag FIFO errors
   output reg         tag_fifo_write_error,
   output reg         tag_fifo_read_error
);
   wire                     fifo_in_ready;
   wire                     fifo_out_valid;
   wire [`TPOI_WORD_W-1:0]  fifo_out_data;
   wire [`TPOI_WORD_W-1:0]  fifo_in_data;
   reg                      fifo_pop;
   reg                      load_pending_q;
   wire                     wr_err;
   wire                     rd_err;
   // Decoded fields of the drained word
   wire [1:0]               f_op;
   wire                     f_upd;
   wire                     f_skew;
   wire [4:0]               f_lane;
   wire [15:0]              f_csum;
   wire [15:0]              f_stamp;
   wire [15:0]              f_tag;
   wire                     f_one;
   wire                     f_fix;
   wire [15:0]              csum_limit;
   wire                     odd_ofs;
   wire                     tc_over;
   // Shadow of the FIFO fill level for the client's ready
   wire                     fifo_push;
   reg  [3:0]               fill_q;
   reg  [3:0]               fill_d;

   // Pack sideband; skew enable captured per frame as it is a static setting
   assign fifo_in_data = {stamp_operation_select, update_checksum, lane_skew_adjust_enable,
                          sop_lane, checksum_byte_offset, stamp_byte_offset, frame_tag};

   // Write error: start with no room; read error: reserved select in the loaded word
   assign wr_err    = frame_start & ~fifo_in_ready;
   assign rd_err    = load_pending_q & (f_op == `TPOI_OP_RSVD); // Word is stale at the pop itself
   assign fifo_push = frame_start & fifo_in_ready;

   tpoi_fifo #(
      .WIDTH (`TPOI_WORD_W),
      .DEPTH (`TPOI_FIFO_DEPTH),
      .AW    (`TPOI_FIFO_AW)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (frame_start),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );

   // Unpack the word that the FIFO registered one cycle after the pop
   assign f_op    = fifo_out_data[56:55];
   assign f_upd   = fifo_out_data[54];
   assign f_skew  = fifo_out_data[53];
   assign f_lane  = fifo_out_data[52:48];
   assign f_csum  = fifo_out_data[47:32];
   assign f_stamp = fifo_out_data[31:16];
   assign f_tag   = fifo_out_data[15:0];
   assign f_one   = (f_op == `TPOI_OP_ONE_STEP);
   assign f_fix   = f_one & f_upd;
   assign csum_limit = f_csum + `TPOI_TC_MAX_SPAN;
   // Odd offsets and an out-of-range correction field are flagged, not fixed
   assign odd_ofs = f_one & (f_stamp[0] | (f_fix & f_csum[0]));
   assign tc_over = f_fix & transparent_clock_mode & (f_stamp > csum_limit);

   // Pop when the job slot is free or being taken; RAM read data appears next cycle
   always @* begin
      fifo_pop = fifo_out_valid & ~load_pending_q & (~job_valid | job_ready);
   end

   // Job slot loaded from the FIFO output one cycle after each pop
   always @(posedge clk) begin
      if (!rst_n) begin
         load_pending_q          <= 1'b0;
         job_valid               <= 1'b0;
         job_insert              <= 1'b0;
         job_return_stamp        <= 1'b0;
         job_fix_checksum        <= 1'b0;
         job_checksum_offset     <= 16'h0000;
         job_field_offset        <= 16'h0000;
         job_field_is_correction <= 1'b0;
         job_skew_adjust         <= 16'h0000;
         job_tag                 <= 16'h0000;
         job_offset_error        <= 1'b0;
      end else begin
         load_pending_q <= fifo_pop;
         if (load_pending_q) begin
            job_valid        <= 1'b1;
            job_insert       <= f_one;
            job_return_stamp <= (f_op == `TPOI_OP_TWO_STEP);
            // Without the flag no checksum byte is touched
            job_fix_checksum <= f_fix;
            // Offset zeroed when not used so stale values never steer the engine
            job_checksum_offset <= f_fix ? f_csum : 16'h0000;
            job_field_offset    <= f_one ? f_stamp : 16'h0000;
            job_field_is_correction <= f_one & transparent_clock_mode;
            // Skew correction only applies to one-step frames
            job_skew_adjust <= (f_one & f_skew) ? ({11'h000, f_lane} * `TPOI_SKEW_STEP) : 16'h0000;
            job_tag          <= f_tag;
            job_offset_error <= odd_ofs | tc_over;
         end else if (job_ready) begin
            job_valid <= 1'b0;
         end
      end
   end

   // Next fill level; mirrors the FIFO's own push and pop
   always @* begin
      fill_d = fill_q;
      if (fifo_push & ~fifo_pop) begin
         fill_d = fill_q + 4'h1;
      end else if (fifo_pop & ~fifo_push) begin
         fill_d = fill_q - 4'h1;
      end
   end

   // Shadow fill register
   always @(posedge clk) begin
      if (!rst_n) begin
         fill_q <= 4'h0;
      end else begin
         fill_q <= fill_d;
      end
   end

   // Ready counts this edge's push, so a start seen with ready high always fits
   always @(posedge clk) begin
      if (!rst_n) begin
         sideband_ready <= 1'b0;
      end else begin
         sideband_ready <= (fill_d != `TPOI_FIFO_FULL);
      end
   end

   // Sticky errors; only the transmit path reset clears them
   always @(posedge clk) begin
      if (!rst_n) begin
         tag_fifo_write_error <= 1'b0;
         tag_fifo_read_error  <= 1'b0;
      end else begin
         if (wr_err) begin
            tag_fifo_write_error <= 1'b1;
         end
         if (rd_err) begin
            tag_fifo_read_error <= 1'b1;
         end
      end
   end
endmodule // tpoi_ctrl

//--- core/tpoi_defines.vh
// Constants for the transmit one-step stamp insertion control block
`ifndef TPOI_DEFINES_VH
`define TPOI_DEFINES_VH
// Operation select encodings
`define TPOI_OP_NONE      2'h0
`define TPOI_OP_ONE_STEP  2'h1
`define TPOI_OP_TWO_STEP  2'h2
`define TPOI_OP_RSVD      2'h3
// Field widths
`define TPOI_OFS_W        16
`define TPOI_TAG_W        16
`define TPOI_LANE_W       5
// Tag FIFO word: op(2) upd(1) skew(1) lane(5) csum ofs(16) stamp ofs(16) tag(16)
`define TPOI_WORD_W       57
`define TPOI_FIFO_DEPTH   8
`define TPOI_FIFO_AW      3
// Fill level at which the client sees no room
`define TPOI_FIFO_FULL    4'h8
// Correction field length beyond the checksum offset in transparent mode
`define TPOI_TC_MAX_SPAN  16'h0022
// Lane skew step per PCS lane, in timestamp nanosecond units
`define TPOI_SKEW_STEP    16'h0001
`endif

//--- core/tpoi_fifo.v
// Parameterised first-in first-out buffer for per-frame tag words
`timescale 1ns/100ps
module tpoi_fifo #(
   parameter WIDTH = 57,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // Clock and reset
   input  wire             clk,
   input  wire             rst_n,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output reg  [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_q;
   reg [AW-1:0]    rd_ptr_q;
   reg [AW:0]      count_q;
   wire            push;
   wire            pop;

   assign in_ready  = (count_q != DEPTH[AW:0]);
   assign out_valid = (count_q != {(AW+1){1'b0}});
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Storage write, no reset needed on the array
   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_q] <= in_data;
      end
   end

   // Registered read data follows the read pointer one cycle later
   always @(posedge clk) begin
      out_data <= mem[rd_ptr_q];
   end

   // Pointers and fill count
   always @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         count_q  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         if (push & ~pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop & ~push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end
endmodule // tpoi_fifo

//--- verif/tpoi_chk_asserts.sv
// Checker of the stamp insertion control ports
`timescale 1ns/100ps
module tpoi_chk (
   // Clock and transmit path reset
   input wire        clk,
   input wire        rst_n,
   // Job handshake
   input wire        job_ready,
   input wire        job_valid,
   // Job fields
   input wire        job_insert,
   input wire        job_return_stamp,
   input wire        job_fix_checksum,
   input wire        job_field_is_correction,
   input wire [15:0] job_checksum_offset,
   input wire [15:0] job_field_offset,
   input wire [15:0] job_skew_adjust,
   input wire [15:0] job_tag,
   // Configuration and sticky status
   input wire        transparent_clock_mode,
   input wire        tag_fifo_write_error,
   input wire        tag_fifo_read_error
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Errors clear only by reset
   a_wr_err_sticky: assert property (tag_fifo_write_error |=> tag_fifo_write_error)
      else $error("write error fell");
   a_rd_err_sticky: assert property (tag_fifo_read_error |=> tag_fifo_read_error)
      else $error("read error fell");
   // Checksum and field data only matter for one-step jobs
   a_csum_ignored: assert property (job_valid && !job_insert |-> !job_fix_checksum)
      else $error("fix outside one-step");
   a_csum_untouched: assert property (job_valid && !job_fix_checksum
      |-> job_checksum_offset == 16'h0) else $error("checksum offset used");
   a_field_ignored: assert property (job_valid && !job_insert
      |-> job_field_offset == 16'h0 && job_skew_adjust == 16'h0) else $error("field used");
   a_corr_mode: assert property (job_valid && job_field_is_correction
      |-> job_insert && transparent_clock_mode) else $error("correction out of mode");
   a_op_single: assert property (job_valid |-> !(job_insert && job_return_stamp))
      else $error("insert and return");
   // A stalled job must not change under the engine
   a_job_hold: assert property (job_valid && !job_ready
      |=> job_valid && $stable(job_tag) && $stable(job_field_offset)) else $error("job moved");
   c_insert: cover property (job_valid && job_ready && job_insert);
   c_corr: cover property (job_valid && job_ready && job_field_is_correction);
   c_wr_err: cover property ($rose(tag_fifo_write_error));
   c_rd_err: cover property ($rose(tag_fifo_read_error));
endmodule // tpoi_chk
bind tpoi_ctrl tpoi_chk chk_u (
   .clk                     (clk),
   .rst_n                   (rst_n),
   .job_ready               (job_ready),
   .job_valid               (job_valid),
   .job_insert              (job_insert),
   .job_return_stamp        (job_return_stamp),
   .job_fix_checksum        (job_fix_checksum),
   .job_field_is_correction (job_field_is_correction),
   .job_checksum_offset     (job_checksum_offset),
   .job_field_offset        (job_field_offset),
   .job_skew_adjust         (job_skew_adjust),
   .job_tag                 (job_tag),
   .transparent_clock_mode  (transparent_clock_mode),
   .tag_fifo_write_error    (tag_fifo_write_error),
   .tag_fifo_read_error     (tag_fifo_read_error)
);

//--- verif/tpoi_engine_model.sv
// Insertion engine stand-in taking jobs promptly, slowly or never
`timescale 1ns/100ps
module tpoi_engine_model (
   // Clock and pacing, 0 prompt 1 random 2 stalled
   input  wire       clk,
   input  wire [1:0] mode,
   // Job acceptance
   output reg        job_ready = 1'b0
);
   reg [7:0] lfsr_q = 8'h5a;
   // Ready moves at the falling edge so the rising edge sees it settled
   always @(negedge clk) begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      job_ready <= (mode == 2'h0) ? 1'b1 : ((mode == 2'h1) ? lfsr_q[0] : 1'b0);
   end
endmodule // tpoi_engine_model

//--- verif/tb.sv
// Self-checking bench for the stamp insertion control block
`timescale 1ns/100ps
`include "tpoi_defines.vh"
module tb;
   reg         clk = 1'b0, rst_n = 1'b0, frame_start = 1'b0, upd = 1'b0, skew_en = 1'b0, tc = 1'b0;
   reg  [1:0]  op = 2'h0, mode = 2'h0;
   reg  [15:0] cofs = 16'h0, sofs = 16'h0, tag = 16'h0;
   reg  [4:0]  lane = 5'h0;
   wire        job_ready, job_valid, ins, ret, fix, corr, oerr, sb_ready, wr_err, rd_err;
   wire [15:0] j_cofs, j_fofs, j_skew, j_tag;
   reg  [68:0] exp_q[$];
   reg  [68:0] exp_word, got_word;
   reg  [31:0] rng = 32'h0000001c;
   integer     error_cnt = 0, cmp_count = 0, cyc = 0, i, p;
   always #2 clk = ~clk;
   // Reserved stamp input held at zero
   tpoi_ctrl dut_u (.clk(clk), .rst_n(rst_n), .frame_start(frame_start), .stamp_operation_select(op),
      .update_checksum(upd), .checksum_byte_offset(cofs), .stamp_byte_offset(sofs), .frame_tag(tag),
      .sop_lane(lane), .reserved_rx_stamp_input(64'h0), .lane_skew_adjust_enable(skew_en),
      .transparent_clock_mode(tc), .job_ready(job_ready), .job_valid(job_valid), .job_insert(ins),
      .job_return_stamp(ret), .job_fix_checksum(fix), .job_checksum_offset(j_cofs), .job_field_offset(j_fofs),
      .job_field_is_correction(corr), .job_skew_adjust(j_skew), .job_tag(j_tag), .job_offset_error(oerr),
      .sideband_ready(sb_ready), .tag_fifo_write_error(wr_err), .tag_fifo_read_error(rd_err));
   tpoi_engine_model eng_u (.clk(clk), .mode(mode), .job_ready(job_ready));
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   // Expected job word; tag only kept for stamping operations, error for odd or over-span offsets
   function [68:0] expect_job(input [1:0] o, input u, input [15:0] c, s, t, input [4:0] l);
      reg i1, f1;
      begin
         i1 = (o == `TPOI_OP_ONE_STEP);
         f1 = i1 & u;
         expect_job = {i1, o == `TPOI_OP_TWO_STEP, f1, f1 ? c : 16'h0, i1 ? s : 16'h0, i1 & tc,
            (i1 & skew_en) ? {11'h0, l} * `TPOI_SKEW_STEP : 16'h0, (o == 2'h1 || o == 2'h2) ? t : 16'h0,
            (f1 & tc & (s > c + 16'h0022)) | (i1 & (s[0] | (f1 & c[0])))};
      end
   endfunction
   task check(input [68:0] g, e);
      begin
         cmp_count = cmp_count + 1;
         if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("mismatches=%0d compares=%0d", error_cnt, cmp_count);
         if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   // One frame with its sideband, a one-cycle start pulse
   task send(input [1:0] o, input u, input [15:0] c, s);
      integer w;
      begin
         @(negedge clk);
         for (w = 0; w < 50 && sb_ready !== 1'b1; w = w + 1) @(negedge clk);
         rng = xs(rng);
         {op, upd, cofs, sofs, tag} = {o, u, c, s, rng[15:0]};
         lane = rng[20:16] % 5'h14;
         frame_start = 1'b1;
         exp_q.push_back(expect_job(o, u, c, s, tag, lane));
         @(negedge clk) frame_start = 1'b0;
      end
   endtask
   task drain;
      integer w;
      begin
         for (w = 0; w < 300 && exp_q.size() > 0; w = w + 1) @(negedge clk);
         check({68'h0, exp_q.size() > 0}, 69'h0);
      end
   endtask
   // Job taken at each handshake edge; a cycle ceiling cuts hangs
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc > 20000) begin
         error_cnt = error_cnt + 1;
         report_and_stop;
      end else if (rst_n && job_valid === 1'b1 && job_ready === 1'b1) begin
         // A job with nothing expected can never match the all-ones word
         exp_word = (exp_q.size() > 0) ? exp_q.pop_front() : {69{1'b1}};
         got_word = {ins, ret, fix, j_cofs, j_fofs, corr, j_skew, (ins | ret) ? j_tag : 16'h0, oerr};
         check(got_word, exp_word);
      end
   end
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      for (p = 0; p < 4; p = p + 1) begin
         {tc, skew_en} = p[1:0];
         mode = {1'b0, p[0]};
         for (i = 0; i < 24; i = i + 1) begin
            rng = xs(rng);
            cofs = {2'h0, rng[15:3], 1'b0};
            send(rng[1:0] == 2'h3 ? 2'h1 : rng[1:0], rng[2], cofs, cofs + {11'h0, rng[20:17], 1'b0});
            if (i % 6 == 5) drain;
         end
         send(2'h1, 1'b1, 16'h0100, 16'h0122);
         send(2'h1, 1'b1, 16'h0100, 16'h0124);
         send(2'h1, 1'b1, 16'h3ffe, 16'h0000);
         send(2'h1, 1'b1, 16'h0011, 16'h0020);
         send(2'h1, 1'b0, 16'h0010, 16'h0033);
         drain;
      end
      check({66'h0, sb_ready, wr_err, rd_err}, 69'h4);
      send(2'h3, 1'b1, 16'h0010, 16'h0020);
      drain;
      repeat (3) @(negedge clk);
      check({66'h0, sb_ready, wr_err, rd_err}, 69'h5);
      // Stalled engine and a start every cycle: FIFO fills, excess frames refused
      mode = 2'h2;
      frame_start = 1'b1;
      repeat (14) @(negedge clk);
      frame_start = 1'b0;
      repeat (3) @(negedge clk);
      check({66'h0, sb_ready, wr_err, rd_err}, 69'h3);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      exp_q.delete();
      check({66'h0, sb_ready, wr_err, rd_err}, 69'h0);
      // Path must carry frames again after the transmit reset
      mode = 2'h0;
      send(2'h2, 1'b0, 16'h0000, 16'h0000);
      drain;
      report_and_stop;
   end
endmodule // tb
